// ===== dpcc_pkg.sv
// dpcc_pkg: register indices, field layout, reset values and swing constants
// of the converter power and clock control register slice.
// assumes: byte address of a register is four times its index.
package dpcc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 10;
  localparam int REG_W  = 8;

  // register indices
  localparam logic [IDX_W-1:0] IDX_SYSREF_RX_CTRL   = 10'h084;
  localparam logic [IDX_W-1:0] IDX_NV_STARTUP_CTRL  = 10'h085;
  localparam logic [IDX_W-1:0] IDX_OBS_CLOCK_SWING  = 10'h08D;
  localparam logic [IDX_W-1:0] IDX_OBS_CLOCK_DRV_PD = 10'h08F;
  localparam logic [IDX_W-1:0] IDX_CONV_CHAN_PD     = 10'h090;

  // field positions
  localparam int SYNC_PD_BIT  = 0;
  localparam int FIELD_A_LSB  = 4;
  localparam int FIELD_A_W    = 3;
  localparam int BIT_B_POS    = 1;
  localparam int BIT_C_POS    = 0;
  localparam int SWING_W      = 5;
  localparam int DRV_OFF_BIT  = 0;
  localparam int CONV_CHANS   = 2;

  // reset values
  localparam logic                 RST_SYNC_PD  = 1'h0;
  localparam logic [FIELD_A_W-1:0] RST_FIELD_A  = 3'h1;
  localparam logic                 RST_BIT_B    = 1'h1;
  localparam logic                 RST_BIT_C    = 1'h1;
  localparam logic [SWING_W-1:0]   RST_SWING    = 5'h00;
  localparam logic                 RST_DRV_OFF  = 1'h0;
  localparam logic [CONV_CHANS-1:0] RST_CONV_PD = 2'h3;

  // driver level in millivolts
  localparam int LEVEL_W          = 12;
  localparam int SWING_BASE_MV    = 993;
  localparam int SWING_STEP_MV    = 77;
  localparam int SWING_INV_OFFSET = 20;
  localparam int SWING_INV_BIAS_MV = 1000;
  localparam int SWING_LAST_POS   = 9;
  localparam int SWING_LAST_CODE  = 19;
  localparam logic signed [LEVEL_W-1:0] RST_LEVEL_MV = 12'h3E1;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== dpcc_swing_if.sv
// dpcc_swing_if: swing code from the register file to the level decoder.
// assumes: both ends share aclk.
`timescale 1ns/1ps
interface dpcc_swing_if;
  logic [dpcc_pkg::SWING_W-1:0]        code;
  logic signed [dpcc_pkg::LEVEL_W-1:0] level_mv;
  logic                                invert;

  modport regs (output code, input level_mv, input invert);
  modport dec  (input code, output level_mv, output invert);
endinterface

// ===== dpcc_swing_decode.sv
// dpcc_swing_decode: turns the swing code into a signed driver level.
// assumes: code is a registered value on aclk.
`timescale 1ns/1ps
module dpcc_swing_decode (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  dpcc_swing_if.dec  sw
);

  function automatic logic signed [dpcc_pkg::LEVEL_W-1:0] level_of(
    input logic [dpcc_pkg::SWING_W-1:0] code
  );
    int c;
    int mv;
    c = int'(code);
    if (c > dpcc_pkg::SWING_LAST_CODE) begin
      c = dpcc_pkg::SWING_LAST_CODE;
    end
    if (c <= dpcc_pkg::SWING_LAST_POS) begin
      mv = dpcc_pkg::SWING_BASE_MV - c * dpcc_pkg::SWING_STEP_MV; // see RULE6
    end else begin
      mv = (dpcc_pkg::SWING_INV_OFFSET - c) * dpcc_pkg::SWING_STEP_MV
           - dpcc_pkg::SWING_INV_BIAS_MV; // see RULE7
    end
    return dpcc_pkg::LEVEL_W'(mv);
  endfunction

  logic signed [dpcc_pkg::LEVEL_W-1:0] next_level_mv;

  always_comb begin
    next_level_mv = level_of(sw.code);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw.level_mv <= dpcc_pkg::RST_LEVEL_MV;
    end else begin
      sw.level_mv <= next_level_mv;
    end
  end

  // negative level means the output clock is inverted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw.invert <= 1'b0;
    end else begin
      sw.invert <= next_level_mv[dpcc_pkg::LEVEL_W-1]; // see RULE5
    end
  end

endmodule

// ===== dpcc_regs.sv
// dpcc_regs: axi4-lite register slice for sync receiver, start-up control,
// observation clock driver and converter channel power-down.
// assumes: one aclk, synchronous active-low reset, a well-behaved master.
//
// Overview of operation
// RULE1: one bit powers sync receiver on at 0, off at 1; subclass 0 sets it.
// RULE2: sync receiver power-down bit resets to 0, receiver active after reset.
// RULE3: host writes 1 to field a and bit b at start, 0 at end.
// RULE4: host drives bit c low at start, high at end; it resets to 1.
// RULE5: five-bit swing code resets to 0; negative swing inverts the clock.
// RULE6: codes 0 to 9 give 993 mV minus code times 77 mV.
// RULE7: codes 10 to 19 give (20 minus code) times 77 mV, less 1 V.
// RULE8: driver-off bit at 1 disables observation clock driver; resets to 0.
// RULE9: each converter channel has a power-down bit, 1 down, reset 1.
`timescale 1ns/1ps
module dpcc_regs #(
  parameter int ADDR_W = dpcc_pkg::ADDR_W
) (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [ADDR_W-1:0]                   s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [ADDR_W-1:0]                   s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output logic                                     sync_receiver_power_down,
  output logic [dpcc_pkg::FIELD_A_W-1:0]           startup_ctrl_field_a,
  output logic                                     startup_ctrl_bit_b,
  output logic                                     startup_ctrl_bit_c,
  output logic [dpcc_pkg::SWING_W-1:0]             obs_clock_swing_code,
  output logic signed [dpcc_pkg::LEVEL_W-1:0]      obs_clock_level_mv,
  output logic                                     obs_clock_invert,
  output logic                                     obs_clock_driver_off,
  output logic                                     converter0_power_down,
  output logic                                     converter1_power_down
);

  localparam int IW = dpcc_pkg::IDX_W;

  logic [ADDR_W-1:0]              aw_addr;
  logic                           aw_held;
  logic [dpcc_pkg::REG_W-1:0]     w_data;
  logic                           w_lane0;
  logic                           w_held;
  logic                           wr_go;
  logic                           wr_sync;
  logic                           wr_startup;
  logic                           wr_swing;
  logic                           wr_drv_off;
  logic                           wr_conv;
  logic [IW-1:0]                  wr_idx;
  logic [IW-1:0]                  rd_idx;
  logic                           wr_hit;
  logic                           rd_hit;
  logic [dpcc_pkg::REG_W-1:0]     rd_byte;
  logic [dpcc_pkg::CONV_CHANS-1:0] conv_pd;
  dpcc_swing_if                   swing ();

  // ---- write channel ----
  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = IW'(aw_addr >> 2);
  assign rd_idx = IW'(s_axi_araddr >> 2);

  // one store strobe per register; lane 0 alone carries the byte
  assign wr_sync    = wr_go && w_lane0 && wr_idx == dpcc_pkg::IDX_SYSREF_RX_CTRL;
  assign wr_startup = wr_go && w_lane0 && wr_idx == dpcc_pkg::IDX_NV_STARTUP_CTRL;
  assign wr_swing   = wr_go && w_lane0 && wr_idx == dpcc_pkg::IDX_OBS_CLOCK_SWING;
  assign wr_drv_off = wr_go && w_lane0 && wr_idx == dpcc_pkg::IDX_OBS_CLOCK_DRV_PD;
  assign wr_conv    = wr_go && w_lane0 && wr_idx == dpcc_pkg::IDX_CONV_CHAN_PD;

  always_comb begin
    case (wr_idx)
      dpcc_pkg::IDX_SYSREF_RX_CTRL,
      dpcc_pkg::IDX_NV_STARTUP_CTRL,
      dpcc_pkg::IDX_OBS_CLOCK_SWING,
      dpcc_pkg::IDX_OBS_CLOCK_DRV_PD,
      dpcc_pkg::IDX_CONV_CHAN_PD: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  // address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      aw_held <= 1'b1;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  // ready stays low while a response is pending, so one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      w_held <= 1'b1;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data  <= '0;
      w_lane0 <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      w_data  <= s_axi_wdata[dpcc_pkg::REG_W-1:0];
      w_lane0 <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= dpcc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bresp <= wr_hit ? dpcc_pkg::RESP_OKAY : dpcc_pkg::RESP_SLVERR;
    end
  end

  // ---- register storage ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_receiver_power_down <= dpcc_pkg::RST_SYNC_PD; // see RULE2
    end else if (wr_sync) begin
      sync_receiver_power_down <= w_data[dpcc_pkg::SYNC_PD_BIT]; // see RULE1
    end
  end

  // start-up controls reset to 1: field a and bit b in their start state, bit c in its end state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_ctrl_field_a <= dpcc_pkg::RST_FIELD_A; // see RULE3
    end else if (wr_startup) begin
      startup_ctrl_field_a <= w_data[dpcc_pkg::FIELD_A_LSB +: dpcc_pkg::FIELD_A_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_ctrl_bit_b <= dpcc_pkg::RST_BIT_B; // see RULE3
    end else if (wr_startup) begin
      startup_ctrl_bit_b <= w_data[dpcc_pkg::BIT_B_POS];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_ctrl_bit_c <= dpcc_pkg::RST_BIT_C; // see RULE4
    end else if (wr_startup) begin
      startup_ctrl_bit_c <= w_data[dpcc_pkg::BIT_C_POS];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      obs_clock_swing_code <= dpcc_pkg::RST_SWING; // see RULE5
    end else if (wr_swing) begin
      obs_clock_swing_code <= w_data[dpcc_pkg::SWING_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      obs_clock_driver_off <= dpcc_pkg::RST_DRV_OFF; // see RULE8
    end else if (wr_drv_off) begin
      obs_clock_driver_off <= w_data[dpcc_pkg::DRV_OFF_BIT]; // see RULE8
    end
  end

  // one power-down flop per converter channel
  for (genvar ch = 0; ch < dpcc_pkg::CONV_CHANS; ch++) begin : g_conv
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        conv_pd[ch] <= dpcc_pkg::RST_CONV_PD[ch]; // see RULE9
      end else if (wr_conv) begin
        conv_pd[ch] <= w_data[ch]; // see RULE9
      end
    end
  end

  assign converter0_power_down = conv_pd[0];
  assign converter1_power_down = conv_pd[1];

  // ---- swing level decode ----
  assign swing.code = obs_clock_swing_code;

  dpcc_swing_decode u_dpcc_swing_decode (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sw      (swing)
  );

  assign obs_clock_level_mv = swing.level_mv;
  assign obs_clock_invert   = swing.invert;

  // ---- read channel ----
  always_comb begin
    rd_byte = '0;
    rd_hit  = 1'b1;
    case (rd_idx)
      dpcc_pkg::IDX_SYSREF_RX_CTRL: begin
        rd_byte[dpcc_pkg::SYNC_PD_BIT] = sync_receiver_power_down;
      end
      dpcc_pkg::IDX_NV_STARTUP_CTRL: begin
        rd_byte[dpcc_pkg::FIELD_A_LSB +: dpcc_pkg::FIELD_A_W] = startup_ctrl_field_a;
        rd_byte[dpcc_pkg::BIT_B_POS] = startup_ctrl_bit_b;
        rd_byte[dpcc_pkg::BIT_C_POS] = startup_ctrl_bit_c;
      end
      dpcc_pkg::IDX_OBS_CLOCK_SWING: begin
        rd_byte[dpcc_pkg::SWING_W-1:0] = obs_clock_swing_code;
      end
      dpcc_pkg::IDX_OBS_CLOCK_DRV_PD: begin
        rd_byte[dpcc_pkg::DRV_OFF_BIT] = obs_clock_driver_off;
      end
      dpcc_pkg::IDX_CONV_CHAN_PD: begin
        rd_byte[dpcc_pkg::CONV_CHANS-1:0] = conv_pd;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // answer is captured at the address edge and held while rvalid stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= dpcc_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_rdata <= {{(dpcc_pkg::DATA_W - dpcc_pkg::REG_W){1'b0}}, rd_byte};
      s_axi_rresp <= rd_hit ? dpcc_pkg::RESP_OKAY : dpcc_pkg::RESP_SLVERR;
    end
  end

endmodule

// ===== dpcc_regs_assertions.sv
// dpcc_regs_assertions: port checks of the register slice.
// assumes: bound to dpcc_regs; one clock aclk, sync active-low aresetn.
`timescale 1ns/1ps
module dpcc_regs_assertions (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               sync_receiver_power_down,
  input wire logic [2:0]         startup_ctrl_field_a,
  input wire logic               startup_ctrl_bit_b,
  input wire logic               startup_ctrl_bit_c,
  input wire logic [4:0]         obs_clock_swing_code,
  input wire logic signed [11:0] obs_clock_level_mv,
  input wire logic               obs_clock_invert,
  input wire logic               obs_clock_driver_off,
  input wire logic               converter0_power_down,
  input wire logic               converter1_power_down
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_LEVEL_POS: assert property ($past(aresetn) && $past(obs_clock_swing_code) < 10
    |-> int'(obs_clock_level_mv) == 993 - 77 * int'($past(obs_clock_swing_code)))
    else $error("level wrong for low code");
  AST_LEVEL_NEG: assert property ($past(aresetn) && $past(obs_clock_swing_code) inside {[10:19]}
    |-> int'(obs_clock_level_mv) == (20 - int'($past(obs_clock_swing_code))) * 77 - 1000)
    else $error("level wrong for high code");
  AST_INVERT: assert property (obs_clock_invert == (obs_clock_level_mv < 0))
    else $error("invert does not match level sign");
  AST_RESET: assert property ($rose(aresetn) |-> !sync_receiver_power_down
    && startup_ctrl_field_a == 3'h1 && startup_ctrl_bit_b && startup_ctrl_bit_c
    && obs_clock_swing_code == 5'h00 && !obs_clock_driver_off
    && converter0_power_down && converter1_power_down)
    else $error("outputs not at reset values");
  AST_OUT_ON_WRITE: assert property ($past(aresetn) && $changed({sync_receiver_power_down,
    startup_ctrl_field_a, startup_ctrl_bit_b, startup_ctrl_bit_c, obs_clock_swing_code,
    obs_clock_driver_off, converter0_power_down, converter1_power_down}) |-> $rose(s_axi_bvalid))
    else $error("control output changed without a write");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_W_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_READY_BACK: assert property ($fell(s_axi_bvalid) |=> s_axi_awready && s_axi_wready)
    else $error("write channels not ready again");
endmodule

bind dpcc_regs dpcc_regs_assertions u_dpcc_regs_assertions (.*);

// ===== dpcc_regs_bench.sv
// dpcc_regs_bench: self-checking bench driving the slice over axi4-lite.
// assumes: dpcc_pkg, dpcc_regs and the bound checker compiled first.
`timescale 1ns/1ps
module dpcc_regs_bench;
  logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready, sync_pd, bit_b, bit_c, drv, cv0, cv1, inv;
  logic [11:0]        awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic [2:0]         fa;
  logic [4:0]         swing;
  logic signed [11:0] level;
  int                 miscompares, tests_run, e, lag;
  logic [11:0]        at [5] = '{12'h210, 12'h214, 12'h234, 12'h23C, 12'h240};
  logic [7:0]         rt [5] = '{8'h00, 8'h13, 8'h00, 8'h00, 8'h03};
  logic [7:0]         mt [5] = '{8'h01, 8'h73, 8'h1F, 8'h01, 8'h03};

  dpcc_regs u_dpcc_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sync_receiver_power_down(sync_pd), .startup_ctrl_field_a(fa), .startup_ctrl_bit_b(bit_b),
    .startup_ctrl_bit_c(bit_c), .obs_clock_swing_code(swing), .obs_clock_level_mv(level),
    .obs_clock_invert(inv), .obs_clock_driver_off(drv), .converter0_power_down(cv0),
    .converter1_power_down(cv1));

  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= (lag == 0);
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad | awready;
      wd = wd | wready;
      if (ad) awvalid <= 0;
      if (wd) wvalid <= 0;
    end
    if (lag != 0) begin
      repeat (lag) @(posedge aclk);
      bready <= 1;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(bresp, r);
    bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= (lag == 0);
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    if (lag != 0) begin
      repeat (lag) @(posedge aclk);
      rready <= 1;
    end
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, {24'h000000, x});
    chk(rresp, r);
    rready <= 0;
  endtask

  // reset, then registers, outputs and level at their reset values
  task automatic rst;
    aresetn <= 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 5; i++) rd(at[i], rt[i], 2'h0);
    chk({sync_pd, fa, bit_b, bit_c, drv, cv1, cv0}, 32'h03B);
    chk(int'(level), 993);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    print_verdict;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {miscompares, tests_run} = '0;
    lag = 0;
    wstrb = 4'hF;
    rst();
    for (int i = 0; i < 5; i++) begin
      wr(at[i], 8'hFF, 4'hF, 2'h0);
      rd(at[i], mt[i], 2'h0);
    end
    chk({sync_pd, fa, bit_b, bit_c, drv, cv1, cv0}, 32'h1FF);
    wr(12'h214, 8'h12, 4'hF, 2'h0);
    chk({sync_pd, fa, bit_b, bit_c, drv, cv1, cv0}, 32'h137);
    wr(12'h214, 8'h01, 4'hF, 2'h0);
    chk({sync_pd, fa, bit_b, bit_c, drv, cv1, cv0}, 32'h10F);
    for (int c = 0; c < 4; c++) begin
      wr(12'h240, 8'(c), 4'hF, 2'h0);
      chk({cv1, cv0}, c);
    end
    wr(12'h23C, 8'h00, 4'hF, 2'h0);
    chk(drv, 1'b0);
    wr(12'h23C, 8'hFF, 4'h0, 2'h0);
    chk(drv, 1'b0);
    wr(12'h200, 8'hFF, 4'hF, 2'h2);
    rd(12'h200, 8'h00, 2'h2);
    // answers must stand while bready and rready are held low
    lag = 3;
    wr(12'h234, 8'h0A, 4'hF, 2'h0);
    rd(12'h234, 8'h0A, 2'h0);
    lag = 0;
    for (int c = 0; c < 32; c++) begin
      wr(12'h234, 8'(c), 4'hF, 2'h0);
      @(posedge aclk);
      e = (c < 10) ? 993 - 77 * c : (20 - ((c > 19) ? 19 : c)) * 77 - 1000;
      chk(int'(level), e);
      chk({swing, inv}, {c[4:0], e < 0});
    end
    wr(12'h210, 8'h00, 4'hF, 2'h0);
    chk(sync_pd, 1'b0);
    rst();
    print_verdict;
  end
endmodule
